// ### src/option_byte_params.svh
`ifndef OPTION_BYTE_PARAMS_SVH
`define OPTION_BYTE_PARAMS_SVH
// reset (power-on default) values of the two configuration bytes; erasing sets both to 8'hFF
`define MEM_CFG_RESET 8'hFC
`define CLK_CFG_RESET 8'hEF
// reserved positions, forced to one
`define MEM_CFG_RSVD_MASK 8'hF0
`define CLK_CFG_RSVD_MASK 8'h20
// field positions, memory protection byte
`define SEC_HI_BIT 3
`define SEC_LO_BIT 2
`define RDP_BIT 1
`define WRP_BIT 0
// field positions, clock supervisor byte
`define PLL_FACTOR_BIT 7
`define PLL_BYPASS_BIT 6
`define OSC_BIT 4
`define LVD_HI_BIT 3
`define LVD_LO_BIT 2
`define WATCHDOG_SW_ACTIVATION_BIT 1
`define WDG_HALT_BIT 0
`endif

// ### src/option_byte_pkg.sv
package option_byte_pkg;
    typedef enum logic [1:0] {
        SECTOR_HALF_K = 2'h0,
        SECTOR_ONE_K = 2'h1,
        SECTOR_ONE_HALF_K = 2'h2
    } sector_size_type;
    typedef enum logic [1:0] {
        LVD_LOWEST = 2'h0,
        LVD_MEDIUM = 2'h1,
        LVD_HIGHEST = 2'h2,
        LVD_OFF = 2'h3
    } lvd_sel_type;
    typedef struct packed {
        sector_size_type sector0_size_sel;
        logic readout_protect;
        logic flash_write_lock;
        logic pll_factor_x8;
        logic pll_bypass;
        logic rc_osc_off;
        lvd_sel_type low_volt_threshold_sel;
        logic lvd_enable;
        logic watchdog_sw_activation;
        logic watchdog_hw_enable;
        logic halt_reset_enable;
    } settings_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_MASS_ERASE = 2'h1,
        ST_DONE = 2'h3
    } erase_state_type;
endpackage

// ### src/option_byte_config_decoder.sv
`timescale 1ns/10ps
`include "option_byte_params.svh"
// Operation
// - bytes reachable only in programming mode
// - byte0 bits3:2 select sector 0 size
// - byte0 bit1 blocks readout and flash writes
// - erasing readout-protected options first erases memory
// - byte0 bit0 locks memory and itself until the next reset
// - byte1 bit7 selects pll times four/eight
// - byte1 bit6 one bypasses the pll
// - byte1 bit4 one turns rc oscillator off
// - byte1 bits3:2 set detector threshold or off
// - byte1 bit1 selects hardware or software watchdog
// - byte1 bit0 enables reset on halt
module option_byte_config_decoder (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // programming mode pin, asynchronous to mclk
    input wire logic prog_mode_pin,
    // programming tool port
    input wire logic prog_wr,
    input wire logic prog_rd,
    input wire logic prog_erase,
    input wire logic prog_sel,
    input wire logic [7:0] prog_wdata,
    output logic [7:0] prog_rdata,
    output logic prog_refused,
    // handshake with the flash array for the mass erase
    output logic mass_erase_req,
    input wire logic mass_erase_done,
    // decoded settings
    output option_byte_pkg::settings_type settings
);
    logic prog_meta;
    logic prog_mode;
    logic [7:0] memory_protection_config_byte;
    logic [7:0] clock_supervisor_config_byte;
    logic [7:0] next_mem_byte;
    logic [7:0] next_clk_byte;
    logic [7:0] next_rdata;
    logic next_refused;
    logic sampled;
    logic next_sampled;
    option_byte_pkg::erase_state_type state;
    option_byte_pkg::erase_state_type next_state;
    option_byte_pkg::settings_type next_settings;

    // decode a raw pair of bytes into settings
    function automatic option_byte_pkg::settings_type decode(input logic [7:0] b0, input logic [7:0] b1);
        option_byte_pkg::settings_type s;
        s = '0;
        if (b0[`SEC_HI_BIT])
            s.sector0_size_sel = option_byte_pkg::SECTOR_ONE_HALF_K;
        else if (b0[`SEC_LO_BIT])
            s.sector0_size_sel = option_byte_pkg::SECTOR_ONE_K;
        else
            s.sector0_size_sel = option_byte_pkg::SECTOR_HALF_K;
        s.readout_protect = b0[`RDP_BIT];
        s.flash_write_lock = b0[`WRP_BIT] | b0[`RDP_BIT];
        s.pll_factor_x8 = b1[`PLL_FACTOR_BIT];
        s.pll_bypass = b1[`PLL_BYPASS_BIT];
        s.rc_osc_off = b1[`OSC_BIT];
        s.low_volt_threshold_sel = option_byte_pkg::lvd_sel_type'(b1[`LVD_HI_BIT:`LVD_LO_BIT]);
        s.lvd_enable = (b1[`LVD_HI_BIT:`LVD_LO_BIT] != 2'h3);
        s.watchdog_sw_activation = b1[`WATCHDOG_SW_ACTIVATION_BIT];
        s.watchdog_hw_enable = ~b1[`WATCHDOG_SW_ACTIVATION_BIT];
        s.halt_reset_enable = b1[`WDG_HALT_BIT];
        return s;
    endfunction

    // two-flop synchroniser on the mode pin
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prog_meta <= 1'b0;
            prog_mode <= 1'b0;
        end
        else
        begin
            prog_meta <= prog_mode_pin;
            prog_mode <= prog_meta;
        end
    end

    // byte storage, tool access and mass erase sequence
    always_comb
    begin
        next_mem_byte = memory_protection_config_byte;
        next_clk_byte = clock_supervisor_config_byte;
        next_rdata = prog_rdata;
        next_refused = 1'b0;
        next_state = state;
        unique case (state)
            option_byte_pkg::ST_IDLE:
            begin
                if (!prog_mode)
                begin
                    // outside programming mode every access is ignored
                    next_refused = prog_wr | prog_rd | prog_erase;
                end
                else if (prog_erase)
                begin
                    if (memory_protection_config_byte[`WRP_BIT])
                        next_refused = 1'b1;
                    else if (memory_protection_config_byte[`RDP_BIT])
                        next_state = option_byte_pkg::ST_MASS_ERASE;
                    else
                    begin
                        next_mem_byte = 8'hFF;
                        next_clk_byte = 8'hFF;
                    end
                end
                else if (prog_wr)
                begin
                    // write lock also freezes the bytes themselves
                    if (memory_protection_config_byte[`WRP_BIT])
                        next_refused = 1'b1;
                    else if (prog_sel)
                        next_clk_byte = prog_wdata | `CLK_CFG_RSVD_MASK;
                    else
                        next_mem_byte = prog_wdata | `MEM_CFG_RSVD_MASK;
                end
                else if (prog_rd)
                begin
                    next_rdata = prog_sel ? clock_supervisor_config_byte : memory_protection_config_byte;
                end
            end
            option_byte_pkg::ST_MASS_ERASE:
            begin
                // options are cleared only once the array is blank
                if (mass_erase_done)
                begin
                    next_mem_byte = 8'hFF;
                    next_clk_byte = 8'hFF;
                    next_state = option_byte_pkg::ST_DONE;
                end
            end
            option_byte_pkg::ST_DONE:
            begin
                next_state = option_byte_pkg::ST_IDLE;
            end
            default:
            begin
                next_state = option_byte_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            memory_protection_config_byte <= `MEM_CFG_RESET;
            clock_supervisor_config_byte <= `CLK_CFG_RESET;
            prog_rdata <= 8'h00;
            prog_refused <= 1'b0;
            state <= option_byte_pkg::ST_IDLE;
        end
        else
        begin
            memory_protection_config_byte <= next_mem_byte;
            clock_supervisor_config_byte <= next_clk_byte;
            prog_rdata <= next_rdata;
            prog_refused <= next_refused;
            state <= next_state;
        end
    end

    assign mass_erase_req = (state == option_byte_pkg::ST_MASS_ERASE);

    // settings latched once after reset release; later writes never reach them, as reset reloads the default bytes
    always_comb
    begin
        next_settings = settings;
        next_sampled = 1'b1;
        if (!sampled)
            next_settings = decode(memory_protection_config_byte, clock_supervisor_config_byte);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            settings <= decode(`MEM_CFG_RESET, `CLK_CFG_RESET);
            sampled <= 1'b0;
        end
        else
        begin
            settings <= next_settings;
            sampled <= next_sampled;
        end
    end
endmodule

// ### verif/option_byte_checker.sv
`timescale 1ns/10ps
module option_byte_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // tool port
    input wire logic prog_mode_pin,
    input wire logic prog_wr,
    input wire logic prog_rd,
    input wire logic prog_erase,
    input wire logic prog_sel,
    input wire logic [7:0] prog_wdata,
    input wire logic [7:0] prog_rdata,
    input wire logic prog_refused,
    // flash erase handshake and settings
    input wire logic mass_erase_req,
    input wire logic mass_erase_done,
    input wire option_byte_pkg::settings_type settings
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // pin low for three samples so the synchroniser has flushed any high level
    sequence s_req_no_mode;
        !prog_mode_pin [*3] ##0 (prog_wr || prog_rd || prog_erase) && !mass_erase_req;
    endsequence
    a_refuse_no_mode: assert property (s_req_no_mode |=> prog_refused) else $error("access not refused");
    a_refused_cause: assert property (prog_refused |-> $past(prog_wr || prog_rd || prog_erase))
        else $error("refusal without request");
    a_erase_hold: assert property (mass_erase_req && !mass_erase_done |=> mass_erase_req)
        else $error("erase request dropped early");
    a_erase_drop: assert property (mass_erase_req && mass_erase_done |=> !mass_erase_req)
        else $error("erase request stuck");
    a_sector_size: assert property (settings.sector0_size_sel == option_byte_pkg::SECTOR_ONE_HALF_K)
        else $error("sector size wrong");
    a_lock_merge: assert property (settings.readout_protect |-> settings.flash_write_lock)
        else $error("readout protect without write lock");
    a_lvd_enable: assert property (settings.lvd_enable == (settings.low_volt_threshold_sel != 2'h3))
        else $error("detector enable wrong");
    a_wdg_type: assert property (settings.watchdog_hw_enable != settings.watchdog_sw_activation)
        else $error("watchdog type wrong");
    a_settings_hold: assert property ($stable(settings)) else $error("settings moved");
endmodule
bind option_byte_config_decoder option_byte_checker i_checker (.*);

// ### verif/flash_array_model.sv
`timescale 1ns/10ps
module flash_array_model #(
    parameter int ERASE_CYCLES = 5
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // erase handshake
    input wire logic mass_erase_req,
    output logic mass_erase_done
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    // count erase time, restarting whenever the request is withdrawn
    always_comb next_cnt = !mass_erase_req ? 8'h00 : (cnt == 8'(ERASE_CYCLES)) ? cnt : cnt + 8'h01;
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n) cnt <= 8'h00;
        else cnt <= next_cnt;
    end
    // done only while asked, so it falls with the request and never repeats
    assign mass_erase_done = mass_erase_req && (cnt == 8'(ERASE_CYCLES));
endmodule

// ### verif/tb_option_byte_config_decoder.sv
`timescale 1ns/10ps
module tb_option_byte_config_decoder;
    localparam logic [2:0] RD = 3'h1;
    localparam logic [2:0] WR = 3'h2;
    localparam logic [2:0] ER = 3'h4;
    logic mclk, rst_n, prog_mode_pin, prog_wr, prog_rd, prog_erase, prog_sel, prog_refused;
    logic mass_erase_req, mass_erase_done;
    logic [7:0] prog_wdata, prog_rdata;
    option_byte_pkg::settings_type settings;
    int failures, n_compared;
    option_byte_config_decoder i_dut (.mclk(mclk), .rst_n(rst_n), .prog_mode_pin(prog_mode_pin),
        .prog_wr(prog_wr), .prog_rd(prog_rd), .prog_erase(prog_erase), .prog_sel(prog_sel),
        .prog_wdata(prog_wdata), .prog_rdata(prog_rdata), .prog_refused(prog_refused),
        .mass_erase_req(mass_erase_req), .mass_erase_done(mass_erase_done), .settings(settings));
    flash_array_model #(.ERASE_CYCLES(7)) i_flash (.mclk(mclk), .rst_n(rst_n),
        .mass_erase_req(mass_erase_req), .mass_erase_done(mass_erase_done));
    // clock at 25 MHz
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // one strobe pulse; answers are settled at the following falling edge
    task automatic acc(input logic [2:0] op, input logic sel, input logic [7:0] d);
        @(negedge mclk);
        {prog_erase, prog_wr, prog_rd} = op;
        prog_sel = sel;
        prog_wdata = d;
        @(negedge mclk);
        {prog_erase, prog_wr, prog_rd} = 3'h0;
    endtask
    task automatic t_no_mode();
        acc(RD, 1'b0, 8'h00);
        chk(16'(prog_refused), 16'h0001);
        acc(WR, 1'b1, 8'h00);
        chk(16'(prog_refused), 16'h0001);
    endtask
    task automatic t_defaults();
        acc(RD, 1'b0, 8'h00);
        chk({7'h00, prog_refused, prog_rdata}, 16'h00FC);
        acc(RD, 1'b1, 8'h00);
        chk(16'(prog_rdata), 16'h00EF);
        chk(16'(settings), 16'h11B5);
    endtask
    task automatic t_reserved();
        acc(WR, 1'b1, 8'h00);
        acc(RD, 1'b1, 8'h00);
        chk(16'(prog_rdata), 16'h0020);
        chk(16'(settings), 16'h11B5);
    endtask
    // protected erase clears memory first, then leaves both bytes erased
    task automatic t_erase_rdp();
        acc(WR, 1'b0, 8'h02);
        acc(RD, 1'b0, 8'h00);
        chk(16'(prog_rdata), 16'h00F2);
        acc(ER, 1'b0, 8'h00);
        chk(16'(mass_erase_req), 16'h0001);
        for (int i = 0; i < 50 && mass_erase_req !== 1'b0; i++) @(negedge mclk);
        chk(16'(mass_erase_req), 16'h0000);
        @(negedge mclk);
        acc(RD, 1'b0, 8'h00);
        chk(16'(prog_rdata), 16'h00FF);
    endtask
    // erased byte carries the write lock, so writes and erases are refused until reset
    task automatic t_lock();
        acc(WR, 1'b1, 8'h00);
        chk(16'(prog_refused), 16'h0001);
        acc(ER, 1'b0, 8'h00);
        chk({7'h00, prog_refused, 7'h00, mass_erase_req}, 16'h0100);
        acc(RD, 1'b1, 8'h00);
        chk(16'(prog_rdata), 16'h00FF);
    endtask
    task automatic finish_test();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        {rst_n, prog_mode_pin, prog_wr, prog_rd, prog_erase, prog_sel, prog_wdata} = 14'h0000;
        failures = 0;
        n_compared = 0;
        repeat (16) @(negedge mclk);
        rst_n = 1'b1;
        t_no_mode();
        prog_mode_pin = 1'b1;
        repeat (3) @(negedge mclk);
        t_defaults();
        t_reserved();
        t_erase_rdp();
        t_lock();
        finish_test();
    end
    // watchdog well beyond the roughly 55 cycles the tests need
    initial
    begin
        #200000;
        failures++;
        finish_test();
    end
endmodule
